// ===== src/rtc_core.sv
/*
 Real-time clock core with a three-wire serial host port.
 Assumes crystal, serial and supply comparator inputs are asynchronous pins;
 the chip-enable pad carries a pull-down and open-drain wires a pull-up.
*/
`default_nettype none
`include "rtc_cfg.svh"
module rtc_core #(
  parameter int TDELAY_CYCLES = `RTC_TDELAY_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic xtal_clk,
  input wire logic chip_enable,
  input wire logic serial_clk,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic interrupt_out_n_o,
  output logic interrupt_out_n_oe,
  output logic sub_clock_out,
  input wire logic supply_low,
  input wire logic supply_monitor_low,
  output logic supply_good_out_n_o,
  output logic supply_good_out_n_oe,
  output logic charge_switch,
  output logic power_on_flag,
  output logic osc_halt_flag,
  output logic supply_drop_flag
);
  typedef struct packed {
    logic [2:0] xt;
    logic [2:0] sck;
    logic [1:0] ce;
    logic [1:0] sdi;
    logic [1:0] sup;
    logic [1:0] mon;
    logic [15:0] presc;
    logic [7:0] sec, min, hour, wday, day, mon_c, year, trim;
    logic [7:0] awmin, awhour, awdays, admin, adhour, ctrl1, flags;
    logic [11:0] halt_cnt;
    logic min_start;
    rtc_pkg::rtc_phase_t phase;
    logic [2:0] bitcnt;
    logic [7:0] shin, shout;
    logic [3:0] ptr;
    logic sdo, sdo_oe;
    logic [23:0] good_cnt;
    logic good;
    logic clk_out;
  } rtc_state_t;

  rtc_state_t r_reg, r_next;
  rtc_fifo_if #(.WIDTH(12)) wq ();

  rtc_fifo #(.WIDTH(12), .DEPTH(16)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .port(wq.fifo)
  );

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Years 00..99 map to 2000..2099, all multiples of four are leap
  function automatic logic [7:0] last_day(input logic [7:0] m,
      input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  logic xt_tick, sck_rise, sck_fall, ce_on;
  logic sec_evt, half_evt, min_evt, hour_evt, day_evt, mon_evt;
  logic period_evt, adj_sec, wr_en, h24;
  logic [15:0] limit;
  logic [3:0] wr_idx;
  logic [7:0] wr_val, rd_val;
  logic [7:0] hb;

  assign xt_tick = r_reg.xt[1] && !r_reg.xt[2];
  assign sck_rise = r_reg.sck[1] && !r_reg.sck[2];
  assign sck_fall = !r_reg.sck[1] && r_reg.sck[2];
  assign ce_on = r_reg.ce[1];
  assign h24 = r_reg.ctrl1[`RTC_C1_H24];
  assign {wr_idx, wr_val} = wq.out_data;
  // Register writes wait out the calendar update cycle
  assign wq.out_ready = !xt_tick;
  assign wr_en = wq.out_valid && wq.out_ready;

  always_comb begin
    case (r_reg.ptr)
      `RTC_IDX_SEC: rd_val = r_reg.sec;
      `RTC_IDX_MIN: rd_val = r_reg.min;
      `RTC_IDX_HOUR: rd_val = r_reg.hour;
      `RTC_IDX_WDAY: rd_val = r_reg.wday;
      `RTC_IDX_DAY: rd_val = r_reg.day;
      `RTC_IDX_MON: rd_val = r_reg.mon_c;
      `RTC_IDX_YEAR: rd_val = r_reg.year;
      `RTC_IDX_TRIM: rd_val = r_reg.trim;
      `RTC_IDX_AWMIN: rd_val = r_reg.awmin;
      `RTC_IDX_AWHOUR: rd_val = r_reg.awhour;
      `RTC_IDX_AWDAYS: rd_val = r_reg.awdays;
      `RTC_IDX_ADMIN: rd_val = r_reg.admin;
      `RTC_IDX_ADHOUR: rd_val = r_reg.adhour;
      `RTC_IDX_CTRL1: rd_val = r_reg.ctrl1;
      `RTC_IDX_CTRL2: rd_val = r_reg.flags;
      default: rd_val = 8'h00;
    endcase
  end

  always_comb begin
    r_next = r_reg;
    sec_evt = 1'b0;
    half_evt = 1'b0;
    min_evt = 1'b0;
    hour_evt = 1'b0;
    day_evt = 1'b0;
    mon_evt = 1'b0;
    period_evt = 1'b0;
    hb = 8'h00;
    wq.in_valid = 1'b0;
    wq.in_data = {r_reg.ptr, r_reg.shin[6:0], r_reg.sdi[1]};
    r_next.xt = {r_reg.xt[1:0], xtal_clk};
    r_next.sck = {r_reg.sck[1:0], serial_clk};
    r_next.ce = {r_reg.ce[0], chip_enable};
    r_next.sdi = {r_reg.sdi[0], serial_data_line_i};
    r_next.sup = {r_reg.sup[0], supply_low};
    r_next.mon = {r_reg.mon[0], supply_monitor_low};
    r_next.clk_out = r_reg.xt[1];
    r_next.min_start = 1'b0;

    // Every other tens-of-seconds step (x0, x20, x40) gets the trim
    adj_sec = (r_reg.sec[3:0] == 4'h0) && !r_reg.sec[4];
    limit = adj_sec ? `RTC_PRESC_LAST - {{9{r_reg.trim[6]}}, r_reg.trim[6:0]}
                    : `RTC_PRESC_LAST;
    if (xt_tick) begin
      r_next.halt_cnt = '0;
      if (r_reg.presc >= limit) begin
        r_next.presc = '0;
        sec_evt = 1'b1;
      end else begin
        r_next.presc = r_reg.presc + 16'h0001;
      end
      half_evt = sec_evt || (r_reg.presc == `RTC_PRESC_HALF);
    end else if (r_reg.halt_cnt == 12'(`RTC_HALT_CYCLES)) begin
      r_next.flags[`RTC_C2_XSTP] = 1'b1;
    end else begin
      r_next.halt_cnt = r_reg.halt_cnt + 12'h001;
    end

    // BCD time and calendar chain
    if (sec_evt) begin
      r_next.sec = bcd_inc(r_reg.sec);
      if (r_reg.sec == 8'h59) begin
        r_next.sec = 8'h00;
        min_evt = 1'b1;
        r_next.min_start = 1'b1;
        r_next.min = bcd_inc(r_reg.min);
      end
      if (min_evt && r_reg.min == 8'h59) begin
        r_next.min = 8'h00;
        hour_evt = 1'b1;
        hb = {2'b00, r_reg.hour[5:0]};
        if (h24) begin
          day_evt = (r_reg.hour == 8'h23);
          r_next.hour = day_evt ? 8'h00 : bcd_inc(r_reg.hour);
        end else begin
          hb = {3'b000, r_reg.hour[4:0]};
          day_evt = (hb == 8'h11) && r_reg.hour[`RTC_HOUR_PM];
          r_next.hour = (hb == 8'h12) ? 8'h01 : bcd_inc(hb);
          r_next.hour[`RTC_HOUR_PM] = r_reg.hour[`RTC_HOUR_PM] ^ (hb == 8'h11);
        end
      end
      if (day_evt) begin
        r_next.wday = (r_reg.wday == 8'h06) ? 8'h00 : r_reg.wday + 8'h01;
        r_next.day = bcd_inc(r_reg.day);
        if (r_reg.day == last_day(r_reg.mon_c, r_reg.year)) begin
          r_next.day = 8'h01;
          mon_evt = 1'b1;
          r_next.mon_c = (r_reg.mon_c == 8'h12) ? 8'h01 : bcd_inc(r_reg.mon_c);
          if (r_reg.mon_c == 8'h12) begin
            r_next.year = (r_reg.year == 8'h99) ? 8'h00 : bcd_inc(r_reg.year);
          end
        end
      end
    end

    case (rtc_pkg::rtc_period_t'(r_reg.ctrl1[2:0]))
      rtc_pkg::RTC_PI_HALF: period_evt = half_evt;
      rtc_pkg::RTC_PI_SEC: period_evt = sec_evt;
      rtc_pkg::RTC_PI_MIN: period_evt = min_evt;
      rtc_pkg::RTC_PI_HOUR: period_evt = hour_evt;
      rtc_pkg::RTC_PI_DAY: period_evt = day_evt;
      rtc_pkg::RTC_PI_MONTH: period_evt = mon_evt;
      default: period_evt = 1'b0;
    endcase

    // Software writes; a flag bit written as zero is cleared
    if (wr_en) begin
      case (wr_idx)
        `RTC_IDX_SEC: begin
          r_next.sec = wr_val;
          r_next.presc = '0;
        end
        `RTC_IDX_MIN: r_next.min = wr_val;
        `RTC_IDX_HOUR: r_next.hour = wr_val;
        `RTC_IDX_WDAY: r_next.wday = wr_val;
        `RTC_IDX_DAY: r_next.day = wr_val;
        `RTC_IDX_MON: r_next.mon_c = wr_val;
        `RTC_IDX_YEAR: r_next.year = wr_val;
        `RTC_IDX_TRIM: r_next.trim = wr_val;
        `RTC_IDX_AWMIN: r_next.awmin = wr_val;
        `RTC_IDX_AWHOUR: r_next.awhour = wr_val;
        `RTC_IDX_AWDAYS: r_next.awdays = wr_val;
        `RTC_IDX_ADMIN: r_next.admin = wr_val;
        `RTC_IDX_ADHOUR: r_next.adhour = wr_val;
        `RTC_IDX_CTRL1: r_next.ctrl1 = wr_val;
        `RTC_IDX_CTRL2: begin
          r_next.flags = r_next.flags & wr_val;
          r_next.flags[`RTC_C2_CHGOFF] = wr_val[`RTC_C2_CHGOFF];
        end
        default: r_next.flags = r_next.flags;
      endcase
    end

    // Event sets except XSTP are applied last so they win over a same-cycle clear
    if (period_evt) begin
      r_next.flags[`RTC_C2_CTFG] = 1'b1;
    end
    if (r_reg.min_start) begin
      if (r_reg.min == r_reg.admin && r_reg.hour == r_reg.adhour) begin
        r_next.flags[`RTC_C2_DAFG] = 1'b1;
      end
      if (r_reg.min == r_reg.awmin && r_reg.hour == r_reg.awhour &&
          r_reg.awdays[r_reg.wday[2:0]]) begin
        r_next.flags[`RTC_C2_WAFG] = 1'b1;
      end
    end
    if (r_reg.mon[1]) begin
      r_next.flags[`RTC_C2_VDFG] = 1'b1;
    end

    // Serial port: sample on rising edges, drive on falling edges
    if (!ce_on) begin
      r_next.phase = rtc_pkg::RTC_PH_CMD;
      r_next.bitcnt = 3'h0;
      r_next.sdo_oe = 1'b0;
    end else begin
      if (sck_rise) begin
        r_next.shin = {r_reg.shin[6:0], r_reg.sdi[1]};
        r_next.bitcnt = r_reg.bitcnt + 3'h1;
        if (r_reg.bitcnt == 3'h7) begin
          case (r_reg.phase)
            rtc_pkg::RTC_PH_CMD: begin
              // Command byte is {shin[6:0], current bit}: bit6 is shin[5]
              r_next.ptr = {r_reg.shin[2:0], r_reg.sdi[1]};
              r_next.phase = r_reg.shin[5] ? rtc_pkg::RTC_PH_READ
                                           : rtc_pkg::RTC_PH_WRITE;
            end
            rtc_pkg::RTC_PH_WRITE: begin
              wq.in_valid = 1'b1;
              r_next.ptr = r_reg.ptr + 4'h1;
              if (!wq.in_ready) begin
                r_next.flags[`RTC_C2_OVF] = 1'b1;
              end
            end
            default: r_next.phase = r_reg.phase;
          endcase
        end
      end
      if (sck_fall && r_reg.phase == rtc_pkg::RTC_PH_READ) begin
        r_next.sdo_oe = 1'b1;
        if (r_reg.bitcnt == 3'h0) begin
          r_next.sdo = rd_val[7];
          r_next.shout = {rd_val[6:0], 1'b0};
          r_next.ptr = r_reg.ptr + 4'h1;
        end else begin
          r_next.sdo = r_reg.shout[7];
          r_next.shout = {r_reg.shout[6:0], 1'b0};
        end
      end
    end

    // Supply-good delay after recovery
    if (r_reg.sup[1]) begin
      r_next.good = 1'b0;
      r_next.good_cnt = '0;
    end else if (!r_reg.good) begin
      if (r_reg.good_cnt == 24'(TDELAY_CYCLES - 1)) begin
        r_next.good = 1'b1;
      end else begin
        r_next.good_cnt = r_reg.good_cnt + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
      r_reg.day <= `RTC_RST_ONE;
      r_reg.mon_c <= `RTC_RST_ONE;
      r_reg.flags <= `RTC_RST_FLAGS;
      r_reg.phase <= rtc_pkg::RTC_PH_CMD;
    end else begin
      r_reg <= r_next;
    end
  end

  // Interrupt only from an enabled source; enables reset to zero
  assign interrupt_out_n_o = 1'b0;
  assign interrupt_out_n_oe =
    (r_reg.flags[`RTC_C2_WAFG] && r_reg.ctrl1[`RTC_C1_WALE]) ||
    (r_reg.flags[`RTC_C2_DAFG] && r_reg.ctrl1[`RTC_C1_DALE]) ||
    (r_reg.flags[`RTC_C2_CTFG] && r_reg.ctrl1[2:0] != 3'h0);
  assign serial_data_line_o = r_reg.sdo;
  assign serial_data_line_oe = r_reg.sdo_oe && ce_on;
  assign sub_clock_out = r_reg.clk_out;
  assign supply_good_out_n_o = 1'b0;
  assign supply_good_out_n_oe = !r_reg.good;
  assign charge_switch =
    !(r_reg.good && r_reg.flags[`RTC_C2_CHGOFF]);
  assign power_on_flag = r_reg.flags[`RTC_C2_PON];
  assign osc_halt_flag = r_reg.flags[`RTC_C2_XSTP];
  assign supply_drop_flag = r_reg.flags[`RTC_C2_VDFG];
endmodule // rtc_core
`default_nettype wire

// ===== inc/rtc_cfg.svh
/*
 Offsets, field positions, reset values and timing counts of the RTC core.
 Assumes a 100 MHz system clock and a 32.768 kHz crystal clock input.
*/
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define RTC_CLK_MHZ 100
`define RTC_PRESC_LAST 16'h7fff
`define RTC_PRESC_HALF 16'h3fff
`define RTC_HALT_TIME_NS 40000
`define RTC_HALT_CYCLES (`RTC_HALT_TIME_NS * `RTC_CLK_MHZ / 1000)
`define RTC_TDELAY_US 100000
`define RTC_TDELAY_CYCLES (`RTC_TDELAY_US * `RTC_CLK_MHZ)
`define RTC_IDX_SEC 4'h0
`define RTC_IDX_MIN 4'h1
`define RTC_IDX_HOUR 4'h2
`define RTC_IDX_WDAY 4'h3
`define RTC_IDX_DAY 4'h4
`define RTC_IDX_MON 4'h5
`define RTC_IDX_YEAR 4'h6
`define RTC_IDX_TRIM 4'h7
`define RTC_IDX_AWMIN 4'h8
`define RTC_IDX_AWHOUR 4'h9
`define RTC_IDX_AWDAYS 4'ha
`define RTC_IDX_ADMIN 4'hb
`define RTC_IDX_ADHOUR 4'hc
`define RTC_IDX_CTRL1 4'hd
`define RTC_IDX_CTRL2 4'he
`define RTC_HOUR_PM 5
`define RTC_C1_WALE 3
`define RTC_C1_DALE 4
`define RTC_C1_H24 5
`define RTC_C2_CTFG 0
`define RTC_C2_DAFG 1
`define RTC_C2_WAFG 2
`define RTC_C2_VDFG 3
`define RTC_C2_XSTP 4
`define RTC_C2_PON 5
`define RTC_C2_CHGOFF 6
`define RTC_C2_OVF 7
`define RTC_RST_ONE 8'h01
`define RTC_RST_ZERO 8'h00
`define RTC_RST_FLAGS 8'h20
`endif

// ===== inc/rtc_pkg.sv
/*
 Types of the RTC core.
 Assumes rtc_cfg.svh for all numeric constants.
*/
`default_nettype none
package rtc_pkg;
  typedef enum logic [1:0] {
    RTC_PH_CMD = 2'b00,
    RTC_PH_WRITE = 2'b01,
    RTC_PH_READ = 2'b10
  } rtc_phase_t;
  typedef enum logic [2:0] {
    RTC_PI_OFF = 3'b000,
    RTC_PI_HALF = 3'b001,
    RTC_PI_SEC = 3'b010,
    RTC_PI_MIN = 3'b011,
    RTC_PI_HOUR = 3'b100,
    RTC_PI_DAY = 3'b101,
    RTC_PI_MONTH = 3'b110
  } rtc_period_t;
endpackage
`default_nettype wire

// ===== inc/rtc_fifo_if.sv
/*
 Valid/ready carrier between the serial write path and its FIFO.
 Assumes both ends run on the same clock.
*/
`default_nettype none
interface rtc_fifo_if #(parameter int WIDTH = 12);
  logic [WIDTH-1:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (input in_data, in_valid, out_ready,
    output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready,
    input in_ready, out_data, out_valid);
endinterface
`default_nettype wire

// ===== src/rtc_fifo.sv
/*
 Show-ahead FIFO whose head word comes out of a register.
 Assumes a single clock and a driver that respects in_ready.
*/
`default_nettype none
module rtc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  rtc_fifo_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [WIDTH-1:0] head;
  } rtc_fifo_state_t;
  rtc_fifo_state_t r_reg, r_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign port.in_ready = (r_reg.count != DEPTH[AW:0]);
  assign port.out_valid = (r_reg.count != '0);
  assign port.out_data = r_reg.head;
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.wr_ptr = r_reg.wr_ptr + AW'(1);
    end
    if (pop) begin
      r_next.rd_ptr = r_reg.rd_ptr + AW'(1);
    end
    r_next.count = r_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Bypass when the word being written becomes the head
    if (push && r_reg.wr_ptr == r_next.rd_ptr) begin
      r_next.head = port.in_data;
    end else begin
      r_next.head = mem[r_next.rd_ptr];
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[r_reg.wr_ptr] <= port.in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // rtc_fifo
`default_nettype wire

// ===== verification/rtc_host_model.sv
/*
 Host processor model driving the three-wire serial port of the RTC core.
 Assumes the bench resolves the data line from both drivers into line.
*/
`default_nettype none
module rtc_host_model (
  output logic chip_enable,
  output logic serial_clk,
  output logic host_data,
  output logic host_data_oe,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam realtime HALF = 62.5;
  initial begin
    chip_enable = 1'b0;
    serial_clk = 1'b0;
    host_data = 1'b0;
    host_data_oe = 1'b0;
  end
  // One command byte and one data byte; rd holds the last byte seen
  task automatic access(input logic [7:0] cmd, input logic [7:0] wd,
    output logic [7:0] rd);
    logic [15:0] bits;
    bits = {cmd, wd};
    rd = 8'h00;
    chip_enable = 1'b1;
    #HALF;
    for (int i = 15; i >= 0; i--) begin
      host_data_oe = (i >= 8) || !cmd[6];
      // A released line shows no stable level
      host_data = host_data_oe ? bits[i] : ~host_data;
      #HALF;
      serial_clk = 1'b1;
      rd = {rd[6:0], line};
      #HALF;
      serial_clk = 1'b0;
    end
    #HALF;
    chip_enable = 1'b0;
    host_data_oe = 1'b0;
    host_data = ~host_data;
  endtask
endmodule // rtc_host_model
`default_nettype wire

// ===== verification/rtc_core_properties.sv
/*
 Port checker of the RTC core.
 Assumes it is bound to rtc_core with the same supply-good delay.
*/
`default_nettype none
module rtc_core_properties #(
  parameter int TDELAY_CYCLES = 20
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic xtal_clk,
  input wire logic chip_enable,
  input wire logic serial_clk,
  input wire logic serial_data_line_i,
  input wire logic serial_data_line_o,
  input wire logic serial_data_line_oe,
  input wire logic interrupt_out_n_o,
  input wire logic interrupt_out_n_oe,
  input wire logic sub_clock_out,
  input wire logic supply_low,
  input wire logic supply_monitor_low,
  input wire logic supply_good_out_n_o,
  input wire logic supply_good_out_n_oe,
  input wire logic charge_switch,
  input wire logic power_on_flag,
  input wire logic osc_halt_flag,
  input wire logic supply_drop_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  int idle_cnt;
  int good_cnt;
  int stall_cnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 0;
      good_cnt <= 0;
      stall_cnt <= 0;
    end else begin
      idle_cnt <= chip_enable ? 0 : idle_cnt + 1;
      good_cnt <= supply_low ? 0 : good_cnt + 1;
      stall_cnt <= (xtal_clk != $past(xtal_clk)) ? 0 : stall_cnt + 1;
    end
  end
  sequence s_power_up;
    $rose(resetn);
  endsequence
  chk_oe_idle: assert property (!chip_enable [*5] |->
    !serial_data_line_oe) else $error("data line driven while idle");
  chk_int_quiet: assert property (s_power_up |->
    !interrupt_out_n_oe [*8]) else $error("interrupt after power up");
  chk_por_state: assert property (s_power_up |->
    power_on_flag && supply_good_out_n_oe && charge_switch)
    else $error("wrong state after power up");
  chk_clk_rise: assert property ($rose(xtal_clk) |->
    ##[2:5] sub_clock_out) else $error("clock output missed a rise");
  chk_clk_fall: assert property ($fell(xtal_clk) |->
    ##[2:5] !sub_clock_out) else $error("clock output missed a fall");
  chk_charge_gate: assert property (!charge_switch |->
    !supply_good_out_n_oe) else $error("charge switch open at low supply");
  chk_good_hold: assert property (good_cnt > 0 &&
    good_cnt < TDELAY_CYCLES |-> supply_good_out_n_oe)
    else $error("supply good released early");
  chk_good_late: assert property (good_cnt == TDELAY_CYCLES + 8 |->
    !supply_good_out_n_oe) else $error("supply good not released");
  chk_good_drop: assert property ($rose(supply_low) |->
    ##[1:4] supply_good_out_n_oe) else $error("supply good not lowered");
  chk_drop_set: assert property (supply_monitor_low [*4] |->
    ##[0:4] supply_drop_flag) else $error("supply drop not latched");
  chk_drop_hold: assert property (supply_drop_flag &&
    idle_cnt > 20 |=> supply_drop_flag) else $error("supply drop lost");
  chk_halt_flag: assert property (stall_cnt == 4010 |->
    osc_halt_flag) else $error("oscillator halt not flagged");
endmodule // rtc_core_properties
`default_nettype wire

// ===== verification/rtc_core_bench.sv
/*
 Self-checking bench of the RTC core with a serial host model.
 Assumes the core's pins are asynchronous and the crystal runs fast.
*/
`default_nettype none
`include "rtc_cfg.svh"
module rtc_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TDELAY = 20;
  logic clk, resetn, xtal_clk, xtal_run, xph, ce, sclk, host_d, line;
  logic supply_low, mon_low, sd_o, sd_oe, int_oe, sg_oe, chg, pon;
  logic halt, drop;
  logic [7:0] rd;
  int errors, total_checks, cycles;
  assign line = sd_oe ? sd_o : host_d;
  rtc_host_model i_rtc_host_model (.chip_enable(ce), .serial_clk(sclk),
    .host_data(host_d), .host_data_oe(), .line(line));
  rtc_core #(.TDELAY_CYCLES(TDELAY)) i_rtc_core (.clk(clk),
    .resetn(resetn), .xtal_clk(xtal_clk), .chip_enable(ce),
    .serial_clk(sclk), .serial_data_line_i(line),
    .serial_data_line_o(sd_o), .serial_data_line_oe(sd_oe),
    .interrupt_out_n_o(), .interrupt_out_n_oe(int_oe),
    .sub_clock_out(), .supply_low(supply_low),
    .supply_monitor_low(mon_low), .supply_good_out_n_o(),
    .supply_good_out_n_oe(sg_oe), .charge_switch(chg),
    .power_on_flag(pon), .osc_halt_flag(halt), .supply_drop_flag(drop));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Crystal of 40 ns period, stoppable
  always @(negedge clk) begin
    xph <= ~xph;
    if (xtal_run && xph) xtal_clk <= ~xtal_clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      end_sim();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [7:0] val);
    i_rtc_host_model.access({4'h0, idx}, val, rd);
    repeat (10) @(negedge clk);
  endtask
  task automatic rd_reg(input logic [3:0] idx);
    i_rtc_host_model.access({4'h4, idx}, 8'h00, rd);
    repeat (4) @(negedge clk);
  endtask
  task automatic t_reset;
    check({pon, chg, sg_oe, int_oe, halt, drop, 2'b00}, 8'he0);
    rd_reg(`RTC_IDX_SEC);
    check(rd, 8'h00);
    rd_reg(`RTC_IDX_DAY);
    check(rd, 8'h01);
    rd_reg(`RTC_IDX_MON);
    check(rd, 8'h01);
    $display("test reset done");
  endtask
  task automatic t_supply;
    repeat (TDELAY + 10) @(negedge clk);
    check({7'h00, sg_oe}, 8'h00);
    wr(`RTC_IDX_CTRL2, 8'hff);
    check({7'h00, chg}, 8'h00);
    supply_low = 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, sg_oe, chg}, 8'h03);
    supply_low = 1'b0;
    repeat (TDELAY + 10) @(negedge clk);
    check({6'h00, sg_oe, chg}, 8'h00);
    $display("test supply done");
  endtask
  task automatic t_flags;
    mon_low = 1'b1;
    repeat (8) @(negedge clk);
    mon_low = 1'b0;
    repeat (8) @(negedge clk);
    check({7'h00, drop}, 8'h01);
    wr(`RTC_IDX_CTRL2, 8'hd7);
    check({6'h00, drop, pon}, 8'h00);
    rd_reg(`RTC_IDX_CTRL2);
    check(rd & 8'h68, 8'h40);
    $display("test flags done");
  endtask
  task automatic t_halt;
    xtal_run = 1'b0;
    repeat (4100) @(negedge clk);
    check({7'h00, halt}, 8'h01);
    xtal_run = 1'b1;
    wr(`RTC_IDX_CTRL2, 8'hef);
    check({7'h00, halt}, 8'h00);
    $display("test halt done");
  endtask
  task automatic t_periodic;
    wr(`RTC_IDX_CTRL1, 8'h21);
    wr(`RTC_IDX_HOUR, 8'h23);
    rd_reg(`RTC_IDX_HOUR);
    check(rd, 8'h23);
    for (int i = 0; i < 65736 && int_oe !== 1'b1; i++) @(negedge clk);
    check({7'h00, int_oe}, 8'h01);
    rd_reg(`RTC_IDX_CTRL2);
    check(rd & 8'h01, 8'h01);
    wr(`RTC_IDX_CTRL1, 8'h20);
    wr(`RTC_IDX_CTRL2, 8'hbe);
    check({7'h00, int_oe}, 8'h00);
    $display("test periodic done");
  endtask
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    errors = 0;
    total_checks = 0;
    cycles = 0;
    resetn = 1'b0;
    supply_low = 1'b0;
    mon_low = 1'b0;
    xtal_clk = 1'b0;
    xtal_run = 1'b1;
    xph = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_supply();
    t_flags();
    t_halt();
    t_periodic();
    end_sim();
  end
endmodule // rtc_core_bench
bind rtc_core rtc_core_properties #(.TDELAY_CYCLES(TDELAY_CYCLES))
  i_rtc_core_properties (.clk(clk), .resetn(resetn), .xtal_clk(xtal_clk),
  .chip_enable(chip_enable), .serial_clk(serial_clk),
  .serial_data_line_i(serial_data_line_i),
  .serial_data_line_o(serial_data_line_o),
  .serial_data_line_oe(serial_data_line_oe),
  .interrupt_out_n_o(interrupt_out_n_o),
  .interrupt_out_n_oe(interrupt_out_n_oe), .sub_clock_out(sub_clock_out),
  .supply_low(supply_low), .supply_monitor_low(supply_monitor_low),
  .supply_good_out_n_o(supply_good_out_n_o),
  .supply_good_out_n_oe(supply_good_out_n_oe),
  .charge_switch(charge_switch), .power_on_flag(power_on_flag),
  .osc_halt_flag(osc_halt_flag), .supply_drop_flag(supply_drop_flag));
`default_nettype wire
